// ===== hw/frg_pkg.sv
package frg_pkg;
    // ==========================================
    // register map and fields
    localparam logic [19:0] ADDR_DFL_CTL = 20'hF_0090;
    localparam logic [19:0] ADDR_FL_MODE = 20'hF_00AA;
    localparam logic [19:0] ADDR_FL_PROT = 20'hF_00AB;
    localparam int DFL_EN_BIT = 0;
    localparam int MODE_HI_BIT = 7;
    localparam int MODE_LO_BIT = 6;
    localparam int BANK_EN_BIT = 1;
    localparam int UNLOCK_BIT = 0;
    localparam logic [7:0] DFL_CTL_MASK = 8'h01;
    localparam logic [7:0] FL_MODE_MASK = 8'hC2;
    localparam logic [7:0] FL_PROT_MASK = 8'h01;
    localparam logic [7:0] RST_DFL_CTL = 8'h00;
    localparam logic [7:0] RST_FL_MODE = 8'h00;
    localparam logic [7:0] RST_FL_PROT = 8'h00;

    // ==========================================
    // code flash geometry
    localparam int BLOCK_LSB = 10;
    localparam int BLOCK_W = 9;
    localparam logic [19:0] BOOT_CLUSTER_LAST = 20'h0_0FFF;
    localparam logic [BLOCK_W-1:0] RST_WIN_START = 9'h000;
    localparam logic [BLOCK_W-1:0] RST_WIN_END = 9'h1FF;

    // ==========================================
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int DFL_SETUP_NS = 5000;
    localparam int DFL_SETUP_CYC = (DFL_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 12;

    // ==========================================
    // types
    typedef enum logic {FRG_SERIAL, FRG_SELF} frg_agent_e;
    typedef enum logic [1:0] {FRG_READ, FRG_WRITE, FRG_ERASE, FRG_FETCH} frg_op_e;
    typedef enum logic [1:0] {DF_OFF, DF_SETUP, DF_READY} frg_dfl_e;

    typedef struct packed {
        logic valid;
        frg_agent_e agent;
        frg_op_e op;
        logic data_area;
        logic byte_size;
        logic [19:0] addr;
    } frg_req_s;

    typedef struct packed {
        logic grant;
        logic refuse;
        logic [BLOCK_W-1:0] block;
    } frg_rsp_s;

    typedef struct packed {
        logic valid;
        frg_agent_e agent;
        logic set_erase_prot;
        logic set_write_prot;
        logic set_bc0_prot;
        logic release_write;
        logic win_valid;
        logic [BLOCK_W-1:0] win_start;
        logic [BLOCK_W-1:0] win_end;
    } frg_sec_s;

    typedef struct packed {
        logic strap_done;
        logic [7:0] fl_mode;
        logic [7:0] fl_prot;
        logic [7:0] dfl_ctl;
        frg_dfl_e df_st;
        logic [CNT_W-1:0] cnt;
        logic erase_prot;
        logic write_prot;
        logic bc0_prot;
        logic [BLOCK_W-1:0] win_start;
        logic [BLOCK_W-1:0] win_end;
        logic [7:0] rdata;
        logic reg_fail;
        frg_rsp_s rsp;
        logic sec_ok;
        logic sec_fail;
        logic stop_grant;
        logic stop_refuse;
    } frg_state_s;
endpackage : frg_pkg

// ===== hw/frg_guard.sv
// What this block does
// - bank update enable 0 refuses bank programming, 1 permits updating other bank.
// - speed mode bits load from the option byte speed bits on the first edge after reset release.
// - mode select writes are ignored while the unlock bit is 0.
// - self-programming erase or write outside the window is refused.
// - serial programming may erase and write outside the window.
// - boot cluster 0 protection wins over the window.
// - the window restricts code flash only, never data flash.
// - erase prohibition refuses serial erase, self-programming erase still runs.
// - write prohibition refuses serial write, self-programming write still runs.
// - boot cluster 0 protection refuses erase and write of 00000H-00FFFH.
// - prohibitions start clear, settable from either mode, in any combination.
// - erase and boot cluster prohibitions can never be cleared.
// - write prohibition clears only serially, others clear, both areas blank.
// - boot cluster protection refused in bank mode; it blocks bank programming.
// - data flash erases in 1 KB blocks, byte access only.
// - data flash cannot be fetched from; background rewrite lets code run.
// - data flash access denied while code flash self-rewrite runs.
// - during data flash rewrite, control writes ignored and STOP refused.
// - bank programming and background data rewrite never run together.
// - data flash control resets to 00H; enable in bit 0.
// - access enable 0 blocks data flash access, 1 permits it.
// - data flash is unavailable for the setup time after enabling.
module frg_guard (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [19:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_fail,
    input wire logic [1:0] option_speed_mode,
    input wire logic boot_flag,
    input wire logic code_self_rewrite,
    input wire logic background_rewrite,
    input wire logic code_blank,
    input wire logic data_blank,
    input wire frg_pkg::frg_req_s req,
    output frg_pkg::frg_rsp_s rsp,
    input wire frg_pkg::frg_sec_s sec,
    output logic sec_ok,
    output logic sec_fail,
    output logic [2:0] prot_flags,
    output logic bank_update_enable,
    output logic data_flash_ready,
    input wire logic stop_req,
    output logic stop_grant,
    output logic stop_refuse
);
    // ==========================================
    // request decode
    frg_pkg::frg_state_s q;
    frg_pkg::frg_state_s d;
    logic req_rewrite;
    logic req_self;
    logic in_bc0;
    logic in_win;
    logic [frg_pkg::BLOCK_W-1:0] req_blk;

    assign req_rewrite = (req.op == frg_pkg::FRG_WRITE) || (req.op == frg_pkg::FRG_ERASE);
    assign req_self = (req.agent == frg_pkg::FRG_SELF);
    assign req_blk = req.addr[frg_pkg::BLOCK_LSB +: frg_pkg::BLOCK_W];
    assign in_bc0 = (req.addr <= frg_pkg::BOOT_CLUSTER_LAST);
    assign in_win = (req_blk >= q.win_start) && (req_blk <= q.win_end);

    // ==========================================
    // next state
    always_comb begin
        logic ok;
        ok = 1'b1;
        d = q;
        d.rsp = '0;
        d.reg_fail = 1'b0;
        d.sec_ok = 1'b0;
        d.sec_fail = 1'b0;
        d.stop_grant = 1'b0;
        d.stop_refuse = 1'b0;

        // the strap is caught on the first edge after release, not by the reset itself
        // speed bits from option byte
        if (!q.strap_done) begin
            d.strap_done = 1'b1;
            d.fl_mode[frg_pkg::MODE_HI_BIT] = option_speed_mode[1];
            d.fl_mode[frg_pkg::MODE_LO_BIT] = option_speed_mode[0];
        end

        if (reg_wr) begin
            case (reg_addr)
                frg_pkg::ADDR_FL_PROT: begin
                    d.fl_prot = reg_wdata & frg_pkg::FL_PROT_MASK;
                end
                frg_pkg::ADDR_FL_MODE: begin
                    if (!q.fl_prot[frg_pkg::UNLOCK_BIT]) begin
                        d.reg_fail = 1'b1;
                    // bank mode blocked by boot cluster protection
                    end else if (reg_wdata[frg_pkg::BANK_EN_BIT] && q.bc0_prot) begin
                        d.reg_fail = 1'b1;
                    // no bank mode during background rewrite
                    end else if (reg_wdata[frg_pkg::BANK_EN_BIT] && background_rewrite) begin
                        d.reg_fail = 1'b1;
                    end else begin
                        d.fl_mode = reg_wdata & frg_pkg::FL_MODE_MASK;
                    end
                end
                frg_pkg::ADDR_DFL_CTL: begin
                    if (background_rewrite) begin
                        d.reg_fail = 1'b1;
                    end else begin
                        d.dfl_ctl = reg_wdata & frg_pkg::DFL_CTL_MASK;
                    end
                end
                default: begin
                end
            endcase
        end

        if (reg_rd) begin
            case (reg_addr)
                frg_pkg::ADDR_FL_PROT: d.rdata = q.fl_prot;
                frg_pkg::ADDR_FL_MODE: d.rdata = q.fl_mode;
                frg_pkg::ADDR_DFL_CTL: d.rdata = q.dfl_ctl;
                default: d.rdata = 8'h00;
            endcase
        end

        if (!d.dfl_ctl[frg_pkg::DFL_EN_BIT]) begin
            d.df_st = frg_pkg::DF_OFF;
            d.cnt = '0;
        end else begin
            case (q.df_st)
                frg_pkg::DF_OFF: begin
                    d.df_st = frg_pkg::DF_SETUP;
                    d.cnt = frg_pkg::CNT_W'(frg_pkg::DFL_SETUP_CYC - 1);
                end
                frg_pkg::DF_SETUP: begin
                    if (q.cnt == '0) begin
                        d.df_st = frg_pkg::DF_READY;
                    end else begin
                        d.cnt = q.cnt - 1'b1;
                    end
                end
                frg_pkg::DF_READY: begin
                end
                default: begin
                    d.df_st = frg_pkg::DF_OFF;
                end
            endcase
        end

        if (req.valid) begin
            if (req.data_area) begin
                if (q.df_st != frg_pkg::DF_READY) begin
                    ok = 1'b0;
                end
                // no data access during code rewrite
                if (code_self_rewrite) begin
                    ok = 1'b0;
                end
                if (req.op == frg_pkg::FRG_FETCH) begin
                    ok = 1'b0;
                end
                if (!req.byte_size) begin
                    ok = 1'b0;
                end
                // no data rewrite in bank mode
                if (req_rewrite && q.fl_mode[frg_pkg::BANK_EN_BIT]) begin
                    ok = 1'b0;
                end
            end else if (req_rewrite) begin
                if (in_bc0 && q.bc0_prot) begin
                    ok = 1'b0;
                end
                // data requests never reach this check
                if (req_self && !in_win) begin
                    ok = 1'b0;
                end
                if (req_self && q.fl_mode[frg_pkg::BANK_EN_BIT] && q.bc0_prot) begin
                    ok = 1'b0;
                end
                if (req_self && q.fl_mode[frg_pkg::BANK_EN_BIT] && background_rewrite) begin
                    ok = 1'b0;
                end
            end
            if (!req_self && req.op == frg_pkg::FRG_ERASE && q.erase_prot) begin
                ok = 1'b0;
            end
            if (!req_self && req.op == frg_pkg::FRG_WRITE && q.write_prot) begin
                ok = 1'b0;
            end
            d.rsp.grant = ok;
            d.rsp.refuse = !ok;
            d.rsp.block = req_blk;
        end

        if (sec.valid) begin
            d.sec_ok = 1'b1;
            if (sec.win_valid) begin
                d.win_start = sec.win_start;
                d.win_end = sec.win_end;
            end
            if (sec.release_write) begin
                if (sec.agent == frg_pkg::FRG_SERIAL && !q.erase_prot && !q.bc0_prot
                        && code_blank && data_blank) begin
                    d.write_prot = 1'b0;
                end else begin
                    d.sec_ok = 1'b0;
                    d.sec_fail = 1'b1;
                end
            end
            // bc0 protection refused in bank mode
            if (sec.set_bc0_prot && q.fl_mode[frg_pkg::BANK_EN_BIT]) begin
                d.sec_ok = 1'b0;
                d.sec_fail = 1'b1;
            end else begin
                // set from either agent, any mix
                // erase and bc0 only ever set here, never cleared; write is also cleared by release
                d.erase_prot = q.erase_prot | sec.set_erase_prot;
                d.bc0_prot = q.bc0_prot | sec.set_bc0_prot;
                d.write_prot = d.write_prot | sec.set_write_prot;
            end
        end

        // STOP would kill the cell sequence mid-program, so it is refused during rewrite and setup
        // STOP refused during rewrite
        if (stop_req) begin
            if (background_rewrite || q.df_st == frg_pkg::DF_SETUP) begin
                d.stop_refuse = 1'b1;
            end else begin
                d.stop_grant = 1'b1;
            end
        end
    end

    // ==========================================
    // state register
    // control resets to 00H
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.fl_mode <= frg_pkg::RST_FL_MODE;
            q.fl_prot <= frg_pkg::RST_FL_PROT;
            q.dfl_ctl <= frg_pkg::RST_DFL_CTL;
            q.df_st <= frg_pkg::DF_OFF;
            q.win_start <= frg_pkg::RST_WIN_START;
            q.win_end <= frg_pkg::RST_WIN_END;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata = q.rdata;
    assign reg_fail = q.reg_fail;
    assign rsp = q.rsp;
    assign sec_ok = q.sec_ok;
    assign sec_fail = q.sec_fail;
    assign prot_flags = {q.bc0_prot, q.write_prot, q.erase_prot};
    assign bank_update_enable = q.fl_mode[frg_pkg::BANK_EN_BIT];
    assign data_flash_ready = (q.df_st == frg_pkg::DF_READY);
    assign stop_grant = q.stop_grant;
    assign stop_refuse = q.stop_refuse;

    // ==========================================
    // checks
    a_unlock_gate: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        q.strap_done && reg_wr && reg_addr == frg_pkg::ADDR_FL_MODE
            && !q.fl_prot[frg_pkg::UNLOCK_BIT]
        |=> $stable(q.fl_mode) && reg_fail)
        else $error("mode select changed while locked");

    a_bc0_refuse: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        req.valid && !req.data_area && req_rewrite && in_bc0 && q.bc0_prot
        |=> rsp.refuse && !rsp.grant)
        else $error("boot cluster rewrite not refused");

    a_window_self: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        req.valid && !req.data_area && req_rewrite && req_self && !in_win
        |=> rsp.refuse)
        else $error("self rewrite outside window granted");

    a_window_serial: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        req.valid && !req.data_area && req.op == frg_pkg::FRG_WRITE && !req_self
            && !in_win && !in_bc0 && prot_flags == 3'b000
        |=> rsp.grant)
        else $error("serial write outside window refused");

    a_serial_erase: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        req.valid && !req_self && req.op == frg_pkg::FRG_ERASE && q.erase_prot
        |=> rsp.refuse)
        else $error("serial erase not refused");

    a_serial_write: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        req.valid && !req_self && req.op == frg_pkg::FRG_WRITE && q.write_prot
        |=> rsp.refuse)
        else $error("serial write not refused");

    a_prot_sticky: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        q.erase_prot && q.bc0_prot |=> (q.erase_prot && q.bc0_prot) [*4])
        else $error("permanent prohibition cleared");

    a_data_denied: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        req.valid && req.data_area && code_self_rewrite |=> rsp.refuse)
        else $error("data access during code rewrite");

    a_setup_wait: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(q.dfl_ctl[frg_pkg::DFL_EN_BIT]) |-> !data_flash_ready [*8])
        else $error("data flash ready before setup");

    a_stop_refuse: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        stop_req && background_rewrite |=> stop_refuse && !stop_grant)
        else $error("stop granted during rewrite");
endmodule : frg_guard

// ===== tb/frg_agent_model.sv
// programming agent at the far side: register bus, flash requests and security commands
module frg_agent_model (
    input wire logic ref_clk,
    output logic [19:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_fail,
    output frg_pkg::frg_req_s req,
    input wire frg_pkg::frg_rsp_s rsp,
    output frg_pkg::frg_sec_s sec,
    input wire logic sec_ok,
    input wire logic sec_fail
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        req = '0;
        sec = '0;
    end

    // ==========================================
    // bus cycles; released address, data and request fields are scrambled, strobes and valid bits drop to 0
    task automatic reg_op(input logic wr, input logic [19:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic f);
        @(posedge ref_clk);
        #1;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, wr, !wr};
        @(posedge ref_clk);
        #1;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = {~a, ~d, 2'b00};
        q = reg_rdata;
        f = reg_fail;
    endtask : reg_op

    task automatic op(input frg_pkg::frg_req_s r, output frg_pkg::frg_rsp_s s);
        @(posedge ref_clk);
        #1;
        req = r | 1'b1 << ($bits(r) - 1);
        @(posedge ref_clk);
        #1;
        req = ~r & ~(1'b1 << ($bits(r) - 1));
        s = rsp;
    endtask : op

    task automatic sc(input frg_pkg::frg_sec_s c, output logic ok, output logic f);
        @(posedge ref_clk);
        #1;
        sec = c | 1'b1 << ($bits(c) - 1);
        @(posedge ref_clk);
        #1;
        sec = ~c & ~(1'b1 << ($bits(c) - 1));
        ok = sec_ok;
        f = sec_fail;
    endtask : sc

    task automatic bank_set(input logic en, output logic f);
        logic [7:0] q;
        logic f0;
        reg_op(1'b0, frg_pkg::ADDR_FL_MODE, 8'h00, q, f0);
        reg_op(1'b1, frg_pkg::ADDR_FL_PROT, 8'h01, q, f0);
        reg_op(1'b1, frg_pkg::ADDR_FL_MODE, {q[7:2], en, q[0]}, q, f);
        reg_op(1'b1, frg_pkg::ADDR_FL_PROT, 8'h00, q, f0);
    endtask : bank_set
endmodule : frg_agent_model

// ===== tb/tb_frg_guard.sv
module tb_frg_guard;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(n, e, s) chk(n, 20'(e), 20'(s))

    logic ref_clk, rst_n, reg_wr, reg_rd, reg_fail, boot_flag, csr, bg, cb, db;
    logic [19:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, q;
    logic [1:0] osm;
    logic [2:0] prot_flags;
    frg_pkg::frg_req_s req;
    frg_pkg::frg_rsp_s rs, rsp;
    frg_pkg::frg_sec_s sec;
    logic sec_ok, sec_fail, bank_en, dfr, stop_req, stop_grant, stop_refuse;
    logic fl, ok, sf, ag, er, ep, wp, bc0;
    logic [8:0] ws, we;
    logic [19:0] a;
    int fails, check_count, n, seed;

    frg_guard i_frg_guard (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_fail(reg_fail), .option_speed_mode(osm), .boot_flag(boot_flag),
        .code_self_rewrite(csr), .background_rewrite(bg), .code_blank(cb),
        .data_blank(db), .req(req), .rsp(rsp), .sec(sec), .sec_ok(sec_ok),
        .sec_fail(sec_fail), .prot_flags(prot_flags), .bank_update_enable(bank_en),
        .data_flash_ready(dfr), .stop_req(stop_req), .stop_grant(stop_grant),
        .stop_refuse(stop_refuse));

    frg_agent_model i_frg_agent_model (.ref_clk(ref_clk), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_fail(reg_fail), .req(req), .rsp(rsp), .sec(sec), .sec_ok(sec_ok),
        .sec_fail(sec_fail));

    // ==========================================
    // helpers
    task automatic chk(string nm, logic [19:0] e, logic [19:0] s);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    task automatic wr(logic [19:0] ad, logic [7:0] d);
        i_frg_agent_model.reg_op(1'b1, ad, d, q, fl);
    endtask : wr

    task automatic rd(logic [19:0] ad);
        i_frg_agent_model.reg_op(1'b0, ad, 8'h00, q, fl);
    endtask : rd

    task automatic op(logic g, logic [1:0] o, logic da, logic bs, logic [19:0] ad);
        i_frg_agent_model.op('{1'b0, frg_pkg::frg_agent_e'(g), frg_pkg::frg_op_e'(o),
            da, bs, ad}, rs);
    endtask : op

    task automatic sc(logic g, logic e, logic w, logic b, logic r, logic wv,
                      logic [8:0] s0, logic [8:0] e0);
        i_frg_agent_model.sc('{1'b0, frg_pkg::frg_agent_e'(g), e, w, b, r, wv, s0, e0},
            ok, sf);
    endtask : sc

    task automatic st();
        @(posedge ref_clk);
        #1 stop_req = 1'b1;
        @(posedge ref_clk);
        #1 stop_req = 1'b0;
    endtask : st

    // expected outcome of a code flash write or erase
    function automatic logic exp_ok(logic self, logic ers, logic [19:0] ad);
        if (bc0 && ad <= frg_pkg::BOOT_CLUSTER_LAST) return 1'b0;
        if (self && (ad[18:10] < ws || ad[18:10] > we)) return 1'b0;
        if (!self && (ers ? ep : wp)) return 1'b0;
        return 1'b1;
    endfunction : exp_ok

    // ==========================================
    // stimulus
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    initial begin
        {rst_n, boot_flag, csr, bg, cb, db, stop_req, ep, wp, bc0} = '0;
        {fails, check_count} = '0;
        osm = 2'b10;
        seed = 49364;
        {ws, we} = {9'h000, 9'h1FF};
        repeat (6) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        rd(frg_pkg::ADDR_DFL_CTL);
        `CHK("dfl_ctl", 8'h00, q);
        rd(frg_pkg::ADDR_FL_MODE);
        `CHK("fl_mode", 8'h80, q);
        `CHK("prot", 3'b000, prot_flags);
        wr(frg_pkg::ADDR_FL_MODE, 8'h82);
        `CHK("locked fail", 1, fl);
        `CHK("bank", 0, bank_en);
        bg = 1'b1;
        i_frg_agent_model.bank_set(1'b1, fl);
        `CHK("bank bg fail", 1, fl);
        bg = 1'b0;
        i_frg_agent_model.bank_set(1'b1, fl);
        `CHK("bank on", 1, bank_en);
        sc(1'b1, 0, 0, 1, 0, 0, 0, 0);
        `CHK("bc0 in bank", 1, sf);
        i_frg_agent_model.bank_set(1'b0, fl);
        `CHK("bank off", 0, bank_en);
        op(1'b1, 2'd0, 1'b1, 1'b1, 20'hF_1000);
        `CHK("df off", 1, rs.refuse);
        wr(frg_pkg::ADDR_DFL_CTL, 8'h01);
        st();
        `CHK("stop setup", 1, stop_refuse);
        op(1'b1, 2'd0, 1'b1, 1'b1, 20'hF_1000);
        `CHK("df setup", 1, rs.refuse);
        n = 0;
        while (dfr !== 1'b1 && n < 1000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n >= 1000) begin
            fails++;
            stop_test();
        end
        // four edges went to the stop and setup probes after the enable write
        `CHK("setup", frg_pkg::DFL_SETUP_CYC - 4, n);
        op(1'b1, 2'd0, 1'b1, 1'b1, 20'hF_1000);
        `CHK("df rd", 1, rs.grant);
        op(1'b1, 2'd0, 1'b1, 1'b0, 20'hF_1000);
        `CHK("df word", 1, rs.refuse);
        op(1'b1, 2'd2, 1'b1, 1'b1, 20'hF_1400);
        `CHK("df blk", 9'h1C5, rs.block);
        op(1'b1, 2'd3, 1'b1, 1'b1, 20'hF_1000);
        `CHK("df fetch", 1, rs.refuse);
        csr = 1'b1;
        op(1'b1, 2'd0, 1'b1, 1'b1, 20'hF_1000);
        `CHK("df csr", 1, rs.refuse);
        {csr, bg} = 2'b01;
        op(1'b1, 2'd3, 1'b0, 1'b1, 20'h0_2000);
        `CHK("bgo fetch", 1, rs.grant);
        wr(frg_pkg::ADDR_DFL_CTL, 8'h00);
        `CHK("ctl bg", 1, fl);
        st();
        `CHK("stop bg", 1, stop_refuse);
        bg = 1'b0;
        st();
        `CHK("stop ok", 1, stop_grant);
        {ws, we} = {9'h004, 9'h006};
        sc(1'b1, 0, 0, 0, 0, 1, ws, we);
        op(1'b1, 2'd1, 1'b1, 1'b1, 20'hF_1000);
        `CHK("win data", 1, rs.grant);
        for (int p = 0; p < 4; p++) begin
            if (p == 1) begin
                sc(1'b0, 0, 1, 0, 0, 0, 0, 0);
                `CHK("sec ok", 1, ok);
                wp = 1'b1;
                `CHK("prot wp", 3'b010, prot_flags);
            end
            if (p == 2) begin
                sc(1'b1, 0, 0, 0, 1, 0, 0, 0);
                `CHK("rel self", 1, sf);
                {cb, db} = 2'b11;
                sc(1'b0, 0, 0, 0, 1, 0, 0, 0);
                wp = 1'b0;
                `CHK("rel ser", 3'b000, prot_flags);
                sc(1'b1, 1, 1, 0, 0, 0, 0, 0);
                {ep, wp} = 2'b11;
                sc(1'b0, 0, 0, 0, 1, 0, 0, 0);
                `CHK("rel ep fail", 1, sf);
                `CHK("rel ep", 3'b011, prot_flags);
            end
            if (p == 3) begin
                sc(1'b0, 0, 0, 1, 0, 0, 0, 0);
                bc0 = 1'b1;
                `CHK("prot all", 3'b111, prot_flags);
                i_frg_agent_model.bank_set(1'b1, fl);
                `CHK("bank bc0", 1, fl);
            end
            for (int i = 0; i < 16; i++) begin
                ag = 1'($random(seed));
                er = 1'($random(seed));
                a = (i < 4) ? 20'h0_0FFF + 20'(i) * 20'h0_0401 : 20'($random(seed)) & 20'h3_FFFF;
                op(ag, er ? 2'd2 : 2'd1, 1'b0, 1'b1, a);
                `CHK("grant", exp_ok(ag, er, a), rs.grant);
                `CHK("refuse", !exp_ok(ag, er, a), rs.refuse);
            end
        end
        stop_test();
    end
endmodule : tb_frg_guard
